//--- rtl/pcmd_pkg.sv
package pcmd_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [11:0] PORT_COMMAND_OFFSET = 12'h004;
    localparam logic [2:0] PORT_COMMAND_FUNC = 3'h0;
    localparam int CMD_W = 16;
    localparam logic [15:0] PORT_COMMAND_RESET = 16'h0000;
    // ****************************************
    // field positions
    // ****************************************
    localparam int BIT_BACK_TO_BACK = 9;
    localparam int BIT_SYS_ERR_MSG = 8;
    localparam int BIT_STEPPING_WAIT = 7;
    localparam int BIT_PARITY_RESP = 6;
    localparam int BIT_PALETTE_SNOOP = 5;
    localparam int BIT_WRITE_INVAL = 4;
    localparam int BIT_SPECIAL_CYCLE = 3;
    // bits owned here that software may change
    localparam logic [15:0] RW_MASK = 16'h0140;
    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic valid;
        logic write;
        logic [2:0] func;
        logic [11:0] offset;
        logic [3:0] byte_en;
        logic [31:0] wdata;
    } pcmd_cfg_req_t;

    typedef struct packed {
        logic fatal;
        logic nonfatal;
        logic correctable;
    } pcmd_err_t;
endpackage : pcmd_pkg

//--- rtl/pcmd_port_command.sv
// Overview of operation
// - bit 9 back-to-back enable reads zero always, writes ignored.
// - bit 8 read-write, reset 0; gates fatal/non-fatal errors onto error pins.
// - error pin reporting also needs matching link device control enables.
// - bridge-type ports forward received fatal/non-fatal messages only when bit 8 set.
// - received correctable messages forward regardless of bit 8.
// - bit 7 stepping wait control reads zero always.
// - bit 6 read-write, reset 0; enables parity checking when set.
// - bit 5 palette snoop enable reads zero always.
// - bit 4 write-invalidate enable reads zero always.
// - bit 3 special cycle enable reads zero always.
// - register decoded at configuration offset 04h of function 0.
// - register is 16 bits; bits 15 to 11 reserved, read zero.
module pcmd_port_command #(
    parameter bit BRIDGE_HEADER = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire pcmd_pkg::pcmd_cfg_req_t cfg_req,
    output logic cfg_ack_ff,
    output logic [31:0] cfg_rdata_ff,
    input wire logic [1:0] link_dev_err_en,
    input wire pcmd_pkg::pcmd_err_t int_err,
    input wire pcmd_pkg::pcmd_err_t rx_err_msg,
    output logic [2:0] err_pin_ff,
    output pcmd_pkg::pcmd_err_t fwd_err_msg_ff,
    output logic parity_check_en_ff,
    output logic [15:0] port_command_ff
);
    // ****************************************
    // decode
    // ****************************************
    logic hit;
    logic [15:0] nxt_cmd;
    logic [15:0] cmd_ff;
    logic sys_err_en;
    logic parity_en;

    assign hit = cfg_req.valid && cfg_req.func == pcmd_pkg::PORT_COMMAND_FUNC
        && cfg_req.offset == pcmd_pkg::PORT_COMMAND_OFFSET;

    // only lanes 0 and 1 carry the command word; status lanes belong elsewhere
    always_comb begin
        nxt_cmd = cmd_ff;
        if (hit && cfg_req.write) begin
            if (cfg_req.byte_en[0]) begin
                nxt_cmd[7:0] = cfg_req.wdata[7:0];
            end
            if (cfg_req.byte_en[1]) begin
                nxt_cmd[15:8] = cfg_req.wdata[15:8];
            end
        end
        nxt_cmd = nxt_cmd & pcmd_pkg::RW_MASK;
    end

    // ****************************************
    // command storage
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_ff <= pcmd_pkg::PORT_COMMAND_RESET;
        end else begin
            cmd_ff <= nxt_cmd;
        end
    end

    assign sys_err_en = cmd_ff[pcmd_pkg::BIT_SYS_ERR_MSG];
    assign parity_en = cmd_ff[pcmd_pkg::BIT_PARITY_RESP];

    // ****************************************
    // read path
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_ack_ff <= 1'b0;
            cfg_rdata_ff <= 32'h0000_0000;
        end else begin
            cfg_ack_ff <= hit;
            // bits 15:11 and hardwired fields come out of the mask as zero
            cfg_rdata_ff <= (hit && !cfg_req.write) ?
                {16'h0000, cmd_ff & pcmd_pkg::RW_MASK} : 32'h0000_0000;
        end
    end

    // ****************************************
    // error signalling
    // ****************************************
    // pin 2 fatal, pin 1 non-fatal, pin 0 correctable (not gated by bit 8)
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            err_pin_ff <= 3'h0;
        end else begin
            err_pin_ff[2] <= int_err.fatal && sys_err_en && link_dev_err_en[1];
            err_pin_ff[1] <= int_err.nonfatal && sys_err_en && link_dev_err_en[0];
            err_pin_ff[0] <= int_err.correctable;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fwd_err_msg_ff <= '0;
        end else begin
            fwd_err_msg_ff.fatal <= BRIDGE_HEADER && sys_err_en && rx_err_msg.fatal;
            fwd_err_msg_ff.nonfatal <= BRIDGE_HEADER && sys_err_en && rx_err_msg.nonfatal;
            fwd_err_msg_ff.correctable <= rx_err_msg.correctable;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            parity_check_en_ff <= 1'b0;
            port_command_ff <= pcmd_pkg::PORT_COMMAND_RESET;
        end else begin
            parity_check_en_ff <= parity_en;
            port_command_ff <= cmd_ff;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    property p_hardwired_zero;
        @(posedge clk) disable iff (!rst_n)
        cfg_ack_ff |-> (cfg_rdata_ff[31:9] == 23'h0 && cfg_rdata_ff[7] == 1'b0
            && cfg_rdata_ff[5:0] == 6'h0);
    endproperty
    a_hardwired_zero: assert property (p_hardwired_zero)
        else $error("hardwired command bit read nonzero");

    property p_write_then_read;
        @(posedge clk) disable iff (!rst_n)
        (hit && cfg_req.write && cfg_req.byte_en[1]) ##1 (hit && !cfg_req.write)
            |=> cfg_rdata_ff[8] == $past(cfg_req.wdata[8], 2);
    endproperty
    a_write_then_read: assert property (p_write_then_read)
        else $error("error message enable readback mismatch");

    property p_fatal_gate;
        @(posedge clk) disable iff (!rst_n)
        err_pin_ff[2] |-> $past(sys_err_en) && $past(link_dev_err_en[1]);
    endproperty
    a_fatal_gate: assert property (p_fatal_gate)
        else $error("fatal error pin without both enables");

    property p_fwd_gate;
        @(posedge clk) disable iff (!rst_n)
        (fwd_err_msg_ff.fatal || fwd_err_msg_ff.nonfatal) |-> $past(sys_err_en);
    endproperty
    a_fwd_gate: assert property (p_fwd_gate)
        else $error("message forwarded while disabled");

    property p_cor_free;
        @(posedge clk) disable iff (!rst_n)
        rx_err_msg.correctable |=> fwd_err_msg_ff.correctable;
    endproperty
    a_cor_free: assert property (p_cor_free)
        else $error("correctable message dropped");

    property p_parity;
        @(posedge clk) disable iff (!rst_n)
        parity_en |=> parity_check_en_ff;
    endproperty
    a_parity: assert property (p_parity)
        else $error("parity enable not propagated");

    property p_ack;
        @(posedge clk) disable iff (!rst_n)
        hit |=> cfg_ack_ff;
    endproperty
    a_ack: assert property (p_ack)
        else $error("decoded access not acknowledged");

    property p_hold;
        @(posedge clk) disable iff (!rst_n)
        !hit |=> $stable(cmd_ff);
    endproperty
    a_hold: assert property (p_hold)
        else $error("command changed without write");

    // ****************************************
    // checks per field
    // ****************************************
    property p_b2b_write;
        @(posedge clk) disable iff (!rst_n)
        hit && cfg_req.write && cfg_req.byte_en[1] && cfg_req.wdata[pcmd_pkg::BIT_BACK_TO_BACK]
            |=> !cmd_ff[pcmd_pkg::BIT_BACK_TO_BACK];
    endproperty
    a_b2b_write: assert property (p_b2b_write)
        else $error("back-to-back enable took a written one");

    property p_step_write;
        @(posedge clk) disable iff (!rst_n)
        hit && cfg_req.write && cfg_req.byte_en[0] && cfg_req.wdata[pcmd_pkg::BIT_STEPPING_WAIT]
            |=> !cmd_ff[pcmd_pkg::BIT_STEPPING_WAIT];
    endproperty
    a_step_write: assert property (p_step_write)
        else $error("stepping wait control took a written one");

    property p_snoop_write;
        @(posedge clk) disable iff (!rst_n)
        hit && cfg_req.write && cfg_req.byte_en[0] && cfg_req.wdata[pcmd_pkg::BIT_PALETTE_SNOOP]
            |=> !cmd_ff[pcmd_pkg::BIT_PALETTE_SNOOP];
    endproperty
    a_snoop_write: assert property (p_snoop_write)
        else $error("palette snoop enable took a written one");

    property p_inval_write;
        @(posedge clk) disable iff (!rst_n)
        hit && cfg_req.write && cfg_req.byte_en[0] && cfg_req.wdata[pcmd_pkg::BIT_WRITE_INVAL]
            |=> !cmd_ff[pcmd_pkg::BIT_WRITE_INVAL];
    endproperty
    a_inval_write: assert property (p_inval_write)
        else $error("write invalidate enable took a written one");

    property p_special_write;
        @(posedge clk) disable iff (!rst_n)
        hit && cfg_req.write && cfg_req.byte_en[0] && cfg_req.wdata[pcmd_pkg::BIT_SPECIAL_CYCLE]
            |=> !cmd_ff[pcmd_pkg::BIT_SPECIAL_CYCLE];
    endproperty
    a_special_write: assert property (p_special_write)
        else $error("special cycle enable took a written one");

    property p_reserved_write;
        @(posedge clk) disable iff (!rst_n)
        hit && cfg_req.write |=> (cmd_ff & ~pcmd_pkg::RW_MASK) == 16'h0000;
    endproperty
    a_reserved_write: assert property (p_reserved_write)
        else $error("reserved command bits took a write");

    property p_err_en_write;
        @(posedge clk) disable iff (!rst_n)
        hit && cfg_req.write && cfg_req.byte_en[1]
            |=> sys_err_en == $past(cfg_req.wdata[pcmd_pkg::BIT_SYS_ERR_MSG]);
    endproperty
    a_err_en_write: assert property (p_err_en_write)
        else $error("error message enable did not take the write");

    property p_parity_write;
        @(posedge clk) disable iff (!rst_n)
        hit && cfg_req.write && cfg_req.byte_en[0]
            |=> parity_en == $past(cfg_req.wdata[pcmd_pkg::BIT_PARITY_RESP]);
    endproperty
    a_parity_write: assert property (p_parity_write)
        else $error("parity response enable did not take the write");

    // ****************************************
    // checks on error paths
    // ****************************************
    property p_nonfatal_gate;
        @(posedge clk) disable iff (!rst_n)
        err_pin_ff[1] |-> $past(sys_err_en) && $past(link_dev_err_en[0]);
    endproperty
    a_nonfatal_gate: assert property (p_nonfatal_gate)
        else $error("non-fatal error pin without both enables");

    property p_fatal_pass;
        @(posedge clk) disable iff (!rst_n)
        int_err.fatal && sys_err_en && link_dev_err_en[1] |=> err_pin_ff[2];
    endproperty
    a_fatal_pass: assert property (p_fatal_pass)
        else $error("enabled fatal error not signalled");

    property p_nonfatal_pass;
        @(posedge clk) disable iff (!rst_n)
        int_err.nonfatal && sys_err_en && link_dev_err_en[0] |=> err_pin_ff[1];
    endproperty
    a_nonfatal_pass: assert property (p_nonfatal_pass)
        else $error("enabled non-fatal error not signalled");

    property p_pin_quiet;
        @(posedge clk) disable iff (!rst_n)
        !sys_err_en |=> !err_pin_ff[2] && !err_pin_ff[1];
    endproperty
    a_pin_quiet: assert property (p_pin_quiet)
        else $error("error pin raised while bit 8 clear");

    property p_fwd_fatal_pass;
        @(posedge clk) disable iff (!rst_n)
        BRIDGE_HEADER && sys_err_en && rx_err_msg.fatal |=> fwd_err_msg_ff.fatal;
    endproperty
    a_fwd_fatal_pass: assert property (p_fwd_fatal_pass)
        else $error("enabled fatal message not forwarded");

    property p_fwd_nonfatal_pass;
        @(posedge clk) disable iff (!rst_n)
        BRIDGE_HEADER && sys_err_en && rx_err_msg.nonfatal |=> fwd_err_msg_ff.nonfatal;
    endproperty
    a_fwd_nonfatal_pass: assert property (p_fwd_nonfatal_pass)
        else $error("enabled non-fatal message not forwarded");

    property p_cor_quiet;
        @(posedge clk) disable iff (!rst_n)
        !rx_err_msg.correctable |=> !fwd_err_msg_ff.correctable;
    endproperty
    a_cor_quiet: assert property (p_cor_quiet)
        else $error("correctable message forwarded without receipt");

    // ****************************************
    // checks on copies and decode
    // ****************************************
    property p_parity_off;
        @(posedge clk) disable iff (!rst_n)
        !parity_en |=> !parity_check_en_ff;
    endproperty
    a_parity_off: assert property (p_parity_off)
        else $error("parity checking on while disabled");

    property p_no_ack;
        @(posedge clk) disable iff (!rst_n)
        !hit |=> !cfg_ack_ff;
    endproperty
    a_no_ack: assert property (p_no_ack)
        else $error("undecoded access acknowledged");

    property p_copy;
        @(posedge clk) disable iff (!rst_n)
        port_command_ff == $past(cmd_ff);
    endproperty
    a_copy: assert property (p_copy)
        else $error("command copy does not follow register");
endmodule : pcmd_port_command

//--- tb/pcmd_host.sv
module pcmd_host (
    input wire logic clk,
    output pcmd_pkg::pcmd_cfg_req_t cfg_req,
    input wire logic cfg_ack_ff,
    input wire logic [31:0] cfg_rdata_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // configuration access, one cycle each
    // ****************************************
    initial cfg_req = '0;
    task automatic access(input logic wr, input logic [2:0] fn, input logic [11:0] off,
        input logic [3:0] be, input logic [31:0] wd, output logic ack, output logic [31:0] rd);
        @(posedge clk);
        cfg_req <= '{valid: 1'b1, write: wr, func: fn, offset: off, byte_en: be, wdata: wd};
        @(posedge clk);
        // idle data inverted so a stale value can never pass
        cfg_req.valid <= 1'b0;
        cfg_req.wdata <= ~wd;
        @(posedge clk);
        ack = cfg_ack_ff;
        rd = cfg_rdata_ff;
    endtask : access
    // write then read with no gap; the read must already see the new word
    task automatic write_read(input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        cfg_req <= '{valid: 1'b1, write: 1'b1, func: 3'h0, offset: 12'h004, byte_en: 4'h3,
            wdata: wd};
        @(posedge clk);
        cfg_req.write <= 1'b0;
        @(posedge clk);
        cfg_req.valid <= 1'b0;
        cfg_req.wdata <= ~wd;
        @(posedge clk);
        rd = cfg_rdata_ff;
    endtask : write_read
endmodule : pcmd_host

//--- tb/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, ack, par, a;
    logic [1:0] link_en;
    logic [2:0] pins, e_pins, e_fwd;
    logic [3:0] be;
    logic [15:0] cmd_q;
    logic [31:0] rdata, r, wd, rv;
    pcmd_pkg::pcmd_err_t int_err, rx_err, fwd, fwd_ep;
    pcmd_pkg::pcmd_cfg_req_t req;
    int num_errors = 0;
    int samples_checked = 0;
    logic [31:0] cmd = 32'h0000_0000;
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    pcmd_host host (.clk(clk), .cfg_req(req), .cfg_ack_ff(ack), .cfg_rdata_ff(rdata));
    pcmd_port_command dut (.clk(clk), .rst_n(rst_n), .cfg_req(req), .cfg_ack_ff(ack),
        .cfg_rdata_ff(rdata), .link_dev_err_en(link_en), .int_err(int_err),
        .rx_err_msg(rx_err), .err_pin_ff(pins), .fwd_err_msg_ff(fwd),
        .parity_check_en_ff(par), .port_command_ff(cmd_q));
    // non-bridge header: fatal and non-fatal messages must never go onward
    pcmd_port_command #(.BRIDGE_HEADER(1'b0)) dut_ep (.clk(clk), .rst_n(rst_n), .cfg_req(req),
        .cfg_ack_ff(), .cfg_rdata_ff(), .link_dev_err_en(link_en), .int_err(int_err),
        .rx_err_msg(rx_err), .err_pin_ff(), .fwd_err_msg_ff(fwd_ep),
        .parity_check_en_ff(), .port_command_ff());
    // ****************************************
    // checking
    // ****************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic test_done();
        $display("checked %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : test_done
    task automatic rd_chk();
        host.access(1'b0, 3'h0, 12'h004, 4'hf, 32'h0000_0000, a, r);
        chk("read ack", 32'h0000_0001, {31'h0, a});
        chk("read data", cmd, r);
    endtask : rd_chk
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        $display("mismatch run time expected under %0d cycles seen %0d", 5000, 5000);
        test_done();
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rst_n = 1'b0;
        link_en = 2'h0;
        int_err = '0;
        rx_err = '0;
        rv = $urandom(65);
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk();
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            wd = $urandom();
            be = 4'($urandom());
            host.access(1'b1, 3'h0, 12'h004, be, wd, a, r);
            chk("write ack", 32'h0000_0001, {31'h0, a});
            if (be[0]) cmd[6] = wd[6];
            if (be[1]) cmd[8] = wd[8];
            rd_chk();
            chk("copy", cmd, {16'h0000, cmd_q});
            chk("parity", {31'h0, cmd[6]}, {31'h0, par});
        end
        host.access(1'b1, 3'h1, 12'h004, 4'hf, 32'hffff_ffff, a, r);
        chk("func ack", 32'h0000_0000, {31'h0, a});
        host.access(1'b0, 3'h0, 12'h008, 4'hf, 32'h0000_0000, a, r);
        chk("offset ack", 32'h0000_0000, {31'h0, a});
        rd_chk();
        $display("test access done");
        for (int i = 0; i < 4; i++) begin
            wd = $urandom();
            host.write_read(wd, r);
            cmd[6] = wd[6];
            cmd[8] = wd[8];
            chk("write then read", cmd, r);
        end
        $display("test back-to-back done");
        for (int s = 0; s < 4; s++) begin
            cmd[8] = s[0];
            host.access(1'b1, 3'h0, 12'h004, 4'h2, cmd, a, r);
            @(negedge clk);
            e_pins = {int_err.fatal & cmd[8] & link_en[1],
                int_err.nonfatal & cmd[8] & link_en[0], int_err.correctable};
            e_fwd = {rx_err.fatal & cmd[8], rx_err.nonfatal & cmd[8], rx_err.correctable};
            repeat (30) begin
                @(posedge clk);
                rv = $urandom();
                int_err <= rv[2:0];
                rx_err <= rv[5:3];
                link_en <= rv[7:6];
                @(negedge clk);
                chk("pins", {29'h0, e_pins}, {29'h0, pins});
                chk("forward", {29'h0, e_fwd}, {29'h0, fwd});
                chk("endpoint forward", {29'h0, 2'b00, e_fwd[0]}, {29'h0, fwd_ep});
                e_pins = {int_err.fatal & cmd[8] & link_en[1],
                    int_err.nonfatal & cmd[8] & link_en[0], int_err.correctable};
                e_fwd = {rx_err.fatal & cmd[8], rx_err.nonfatal & cmd[8], rx_err.correctable};
            end
        end
        $display("test errors done");
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        cmd = 32'h0000_0000;
        rd_chk();
        chk("copy after reset", 32'h0000_0000, {16'h0000, cmd_q});
        chk("parity after reset", 32'h0000_0000, {31'h0, par});
        $display("test second reset done");
        test_done();
    end
endmodule : testbench
